/* core/pss_regs.sv */
module pss_regs
  import pss_pkg::*;
#(
  parameter int MS_COUNT = MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // command port, one-cycle strobes
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  // power stage
  input wire logic start_req,
  input wire pss_cond_t cond_raw,
  output logic ramp_enable,
  output logic power_ok,
  output logic alert_out_n
);
  pss_cond_t c1_q, c_q;
  logic [15:0] delay_q, soft_q;
  pss_state_t st_q;
  logic [31:0] ms_cnt_q;
  logic [15:0] ms_left_q;
  logic ms_tick;
  logic clr;
  logic oc_lat_q, comm_lat_q, unk_lat_q, oc_warn_lat_q;
  logic [7:0] sbyte, svout, siout;
  logic [15:0] sword;
  logic [4:0] ramp_ms;
  logic start_s1_q, start_q;
  logic fault_stop;

  // pins come from outside the clock domain
  // two stages each, so live status trails a pin by two cycles
  always_ff @(posedge clk) begin
    c1_q <= cond_raw;
    c_q <= c1_q;
    start_s1_q <= start_req;
    start_q <= start_s1_q;
  end

  assign clr = cmd_wr && cmd_code == CMD_CLEAR_FAULTS;

  // faults that must drop the output at once
  assign fault_stop = c_q.oc_fault | c_q.vout_ov | c_q.vout_uv |
                      c_q.bad_switch;

  // configuration writes; read-only upper bits stay zero
  always_ff @(posedge clk) begin
    if (srst) begin
      delay_q <= DELAY_RESET;
      soft_q <= SOFT_RESET;
    end else if (cmd_wr && cmd_code == CMD_TURN_ON_DELAY) begin
      // the low eleven bits are clamped at the cap, not wrapped; bits above them are dropped first
      if (cmd_wdata[DELAY_BITS-1:0] > DELAY_MAX[DELAY_BITS-1:0])
        delay_q <= DELAY_MAX;
      else
        delay_q <= {5'h00, cmd_wdata[DELAY_BITS-1:0]};
    end else if (cmd_wr && cmd_code == CMD_SOFT_START) begin
      // all twelve bits are kept; all twelve steer the ramp, any code of 4 or above giving 16 ms
      soft_q <= {4'h0, cmd_wdata[SOFT_BITS-1:0]};
    end
  end

  // codes of 4 and above all map to 16 ms
  always_comb begin
    if (soft_q[SOFT_BITS-1:0] >= 12'h004)
      ramp_ms = 5'(RAMP_MS[4]);
    else
      ramp_ms = 5'(RAMP_MS[soft_q[1:0]]);
  end

  // millisecond tick from a divider held at zero while off or on
  always_ff @(posedge clk) begin
    if (srst || st_q == PSS_OFF || st_q == PSS_ON) ms_cnt_q <= 32'h0;
    else if (ms_tick) ms_cnt_q <= 32'h0;
    else ms_cnt_q <= ms_cnt_q + 32'h1;
  end
  // the divider is not restarted between delay and ramp, so the first
  // ramp millisecond is one clock cycle short of a full divider period
  assign ms_tick = ms_cnt_q == 32'(MS_COUNT - 1);

  // sequencer: delay, then ramp, then regulation
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= PSS_OFF;
      ms_left_q <= 16'h0;
    end else if (!start_q || fault_stop) begin
      // staying off while a fault stands avoids a restart loop
      st_q <= PSS_OFF;
    end else begin
      unique case (st_q)
        PSS_OFF: begin
          st_q <= PSS_DELAY;
          ms_left_q <= 16'(delay_q * DELAY_LSB_MS);
        end
        PSS_DELAY: begin
          if (ms_left_q == 16'h0) begin
            st_q <= PSS_RAMP;
            ms_left_q <= {11'h000, ramp_ms};
          end else if (ms_tick) ms_left_q <= ms_left_q - 16'h1;
        end
        PSS_RAMP: begin
          if (ms_left_q == 16'h0) st_q <= PSS_ON;
          else if (ms_tick) ms_left_q <= ms_left_q - 16'h1;
        end
        PSS_ON: st_q <= PSS_ON;
      endcase
    end
  end

  // latched flags: set wins over clear, clear needs condition gone
  // a clear that meets a standing condition leaves the flag set
  always_ff @(posedge clk) begin
    if (srst) begin
      oc_lat_q <= 1'b0;
      comm_lat_q <= 1'b0;
      unk_lat_q <= 1'b0;
      oc_warn_lat_q <= 1'b0;
    end else begin
      oc_lat_q <= c_q.oc_fault | (oc_lat_q & ~clr);
      comm_lat_q <= c_q.comm_err | (comm_lat_q & ~clr);
      unk_lat_q <= c_q.other_fault | (unk_lat_q & ~clr);
      oc_warn_lat_q <= c_q.oc_warn | (oc_warn_lat_q & ~clr);
    end
  end

  // status assembly
  always_comb begin
    sbyte = 8'h00; // bits 7 and 3 stay zero
    sbyte[SB_OFF] = st_q == PSS_OFF;
    sbyte[SB_VOUT_OV] = c_q.vout_ov;
    sbyte[SB_OC] = oc_lat_q;
    sbyte[SB_THERMAL] = c_q.thermal;
    sbyte[SB_COMM] = comm_lat_q;
    // warning has no own bit here, so it lands in other
    sbyte[SB_OTHER] = c_q.vout_range | c_q.bad_switch | oc_warn_lat_q;
    sword = {8'h00, sbyte};
    sword[SW_VOUT] = c_q.vout_ov | c_q.vout_uv | c_q.vout_range;
    sword[SW_IOUT] = c_q.oc_fault | oc_lat_q | oc_warn_lat_q;
    sword[SW_INPUT] = c_q.input_low;
    sword[SW_PGOOD_N] = st_q != PSS_ON;
    sword[SW_UNKNOWN] = unk_lat_q;
    svout = 8'h00;
    svout[SV_OV] = c_q.vout_ov;
    svout[SV_UV] = c_q.vout_uv;
    svout[SV_MAXMIN] = c_q.vout_range;
    svout[0] = unk_lat_q;
    siout = 8'h00;
    siout[SI_OC] = oc_lat_q;
    siout[SI_OC_UV] = oc_lat_q & c_q.vout_uv;
    siout[SI_OC_WARN] = oc_warn_lat_q;
  end

  // read port: data one cycle after the strobe; byte reads
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_rdata <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        unique case (cmd_code)
          CMD_TURN_ON_DELAY: cmd_rdata <= delay_q;
          CMD_SOFT_START: cmd_rdata <= soft_q;
          CMD_SUMMARY_BYTE: cmd_rdata <= {8'h00, sbyte};
          CMD_SUMMARY_WORD: cmd_rdata <= sword;
          CMD_VOUT_STATUS: cmd_rdata <= {8'h00, svout};
          CMD_IOUT_STATUS: cmd_rdata <= {8'h00, siout};
          // unmapped codes answer zero so every read gets a reply
          default: cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // outputs from flip-flops
  // alert follows the latched flags only; live bits do not pull it
  always_ff @(posedge clk) begin
    if (srst) begin
      ramp_enable <= 1'b0;
      power_ok <= 1'b0;
      alert_out_n <= 1'b1;
    end else begin
      ramp_enable <= st_q == PSS_RAMP || st_q == PSS_ON;
      power_ok <= st_q == PSS_ON;
      alert_out_n <= ~(oc_lat_q | comm_lat_q | unk_lat_q |
                       oc_warn_lat_q);
    end
  end

  // checks: one clock throughout, all but a_reset_vals quiet while reset is held
  // reset leaves both configuration registers at their defaults
  a_reset_vals: assert property (@(posedge clk) srst |=>
    delay_q == DELAY_RESET && soft_q == SOFT_RESET && alert_out_n &&
    !power_ok) else $error("reset values");
  // configuration limits and read-only bits
  a_delay_cap: assert property (@(posedge clk) disable iff (srst)
    delay_q <= DELAY_MAX) else $error("delay above cap");
  a_upper_zero: assert property (@(posedge clk) disable iff (srst)
    delay_q[15:DELAY_BITS] == 5'h00 && soft_q[15:SOFT_BITS] == 4'h0)
    else $error("read-only bits set");
  // soft-start codes of 4 and above share the longest ramp
  a_ramp_16: assert property (@(posedge clk) disable iff (srst)
    soft_q[2] |-> ramp_ms == 5'h10) else $error("ramp code");
  a_ramp_low: assert property (@(posedge clk) disable iff (srst)
    soft_q[11:2] == 10'h000 |-> ramp_ms == 5'h01 << soft_q[1:0])
    else $error("ramp code low");
  // sequencer: no rise before the delay has run out
  a_no_early_rise: assert property (@(posedge clk) disable iff (srst)
    st_q == PSS_DELAY && ms_left_q != 16'h0 |=> st_q != PSS_RAMP)
    else $error("ramp before delay done");
  // each delay step is four milliseconds of the divider
  a_delay_load: assert property (@(posedge clk) disable iff (srst)
    st_q == PSS_OFF ##1 st_q == PSS_DELAY |->
    ms_left_q == {$past(delay_q[13:0]), 2'h0})
    else $error("delay count not four per step");
  // disabled output: over-current and bad-switch faults force it off and the off bit shows it
  a_fault_off: assert property (@(posedge clk) disable iff (srst)
    c_q.oc_fault || c_q.bad_switch |=> sbyte[SB_OFF])
    else $error("fault left output on");
  a_off_bit: assert property (@(posedge clk) disable iff (srst)
    sbyte[SB_OFF] |=> !ramp_enable && !power_ok) else $error("off bit");
  // fixed bits of the status registers
  a_zero_bits: assert property (@(posedge clk) disable iff (srst)
    !sbyte[7] && !sbyte[3] && !sword[12] && sword[10:9] == 2'h0 &&
    sword[SW_PGOOD_N] == (st_q != PSS_ON)) else $error("fixed bits wrong");
  a_vout_zero: assert property (@(posedge clk) disable iff (srst)
    svout[6:5] == 2'h0 && svout[2:1] == 2'h0) else $error("vout zeros");
  // status word views of the same conditions
  a_low_byte: assert property (@(posedge clk) disable iff (srst)
    cmd_rd && cmd_code == CMD_SUMMARY_WORD |=>
    cmd_rdata[7:0] == $past(sbyte)) else $error("word low byte");
  a_vout_sum: assert property (@(posedge clk) disable iff (srst)
    c_q.vout_uv || c_q.vout_range |-> sword[SW_VOUT])
    else $error("vout summary");
  a_iout_sum: assert property (@(posedge clk) disable iff (srst)
    oc_lat_q |-> sword[SW_IOUT]) else $error("iout summary");
  a_ov_both: assert property (@(posedge clk) disable iff (srst)
    c_q.vout_ov |-> sbyte[SB_VOUT_OV] && svout[SV_OV])
    else $error("over-voltage bits");
  a_input_live: assert property (@(posedge clk) disable iff (srst)
    sword[SW_INPUT] == c_q.input_low) else $error("input bit");
  // latched flags: set by the condition, held until a clear
  a_oc_latch: assert property (@(posedge clk) disable iff (srst)
    c_q.oc_fault |=> sbyte[SB_OC]) else $error("oc not latched");
  a_oc_hold: assert property (@(posedge clk) disable iff (srst)
    oc_lat_q && !clr |=> oc_lat_q) else $error("oc dropped");
  a_clear_gated: assert property (@(posedge clk) disable iff (srst)
    oc_lat_q && c_q.oc_fault |=> oc_lat_q)
    else $error("clear beat a standing fault");
  a_comm_latch: assert property (@(posedge clk) disable iff (srst)
    c_q.comm_err |=> comm_lat_q ##1 (comm_lat_q || $past(clr)))
    else $error("comm lost");
  a_unk_latch: assert property (@(posedge clk) disable iff (srst)
    c_q.other_fault |=> sword[SW_UNKNOWN] && svout[0])
    else $error("unknown fault not latched");
  a_warn_alert: assert property (@(posedge clk) disable iff (srst)
    c_q.oc_warn |=> ##1 !alert_out_n) else $error("warning gave no alert");
  // read port answers reads only, one cycle later
  a_read_lat: assert property (@(posedge clk) disable iff (srst)
    cmd_rd && cmd_code == CMD_SUMMARY_BYTE |=> cmd_rvalid &&
    cmd_rdata[15:8] == 8'h00) else $error("byte read");
  a_rvalid_src: assert property (@(posedge clk) disable iff (srst)
    cmd_rvalid |-> $past(cmd_rd)) else $error("answer without read");
  a_write_quiet: assert property (@(posedge clk) disable iff (srst)
    cmd_wr && !cmd_rd |=> !cmd_rvalid) else $error("write answered");
  // main scenarios
  c_reach_on: cover property (@(posedge clk) st_q == PSS_ON);
  c_clear: cover property (@(posedge clk) oc_lat_q ##1 !oc_lat_q);
  c_delay: cover property (@(posedge clk)
    st_q == PSS_DELAY && delay_q != 16'h0);
  c_warn_alert: cover property (@(posedge clk) !alert_out_n ##1 alert_out_n);
  c_fault_off: cover property (@(posedge clk)
    st_q == PSS_ON ##1 st_q == PSS_OFF);
endmodule

/* core/pss_pkg.sv */
package pss_pkg;
  // command codes of the registers
  localparam logic [7:0] CMD_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_SOFT_START = 8'h61;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
  // reset values and writable widths
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] DELAY_MAX = 16'h0100;
  localparam logic [15:0] SOFT_RESET = 16'h0001;
  localparam int DELAY_BITS = 11;
  localparam int SOFT_BITS = 12;
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int DELAY_LSB_MS = 4;
  localparam int MS_CYCLES = CLK_KHZ;
  localparam int RAMP_MS [5] = '{1, 2, 4, 8, 16};
  // summary byte bit positions
  localparam int SB_OFF = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_OC = 4;
  localparam int SB_THERMAL = 2;
  localparam int SB_COMM = 1;
  localparam int SB_OTHER = 0;
  // word, vout and iout bit positions
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_INPUT = 13;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_UNKNOWN = 8;
  localparam int SV_OV = 7;
  localparam int SV_UV = 4;
  localparam int SV_MAXMIN = 3;
  localparam int SI_OC = 7;
  localparam int SI_OC_UV = 6;
  localparam int SI_OC_WARN = 5;
  // sequencer states
  typedef enum logic [1:0] {
    PSS_OFF = 2'b00,
    PSS_DELAY = 2'b01,
    PSS_RAMP = 2'b10,
    PSS_ON = 2'b11
  } pss_state_t;
  // live conditions from the power stage
  typedef struct packed {
    logic vout_ov;
    logic vout_uv;
    logic oc_fault;
    logic oc_warn;
    logic thermal;
    logic bad_switch;
    logic input_low;
    logic vout_range;
    logic other_fault;
    logic comm_err;
  } pss_cond_t;
endpackage

/* tb/pss_host.sv */
module pss_host
  import pss_pkg::*;
(
  // bus side
  input wire logic clk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // {mask, value} of each read, oldest first
  logic [31:0] exp_q[$];
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // one-cycle write strobe; data turned over after so stale data shows
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_wr = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    cmd_wdata = ~d;
  endtask
  // single read per call, byte registers read whole
  task automatic rd(input logic [7:0] c, input logic [15:0] m,
                    input logic [15:0] e);
    exp_q.push_back({m, e});
    @(posedge clk);
    #1;
    cmd_rd = 1'b1;
    cmd_code = c;
    @(posedge clk);
    #1;
    cmd_rd = 1'b0;
    cmd_code = ~c;
  endtask
endmodule

/* tb/pss_regs_test.sv */
module pss_regs_test
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 10;
  logic clk, srst, cmd_wr, cmd_rd, cmd_rvalid;
  logic start_req, ramp_enable, power_ok, alert_out_n;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata;
  pss_cond_t cond;
  int n_errors = 0, total_checks = 0, seed = 32'h3ae64c13, t, e;
  logic [31:0] n;
  // condition bit, register, status bit, latched
  int ci[10] = '{9, 9, 8, 5, 2, 3, 1, 0, 7, 6};
  logic [7:0] cc[10] = '{8'h78, 8'h7a, 8'h7a, 8'h78, 8'h7a, 8'h79, 8'h79,
                         8'h78, 8'h78, 8'h78};
  int bi[10] = '{5, 7, 4, 2, 3, 13, 8, 1, 4, 0};
  bit lt[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1};

  pss_regs #(.MS_COUNT(MSC)) DUT (.clk(clk), .srst(srst), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .start_req(start_req),
    .cond_raw(cond), .ramp_enable(ramp_enable), .power_ok(power_ok),
    .alert_out_n(alert_out_n));
  pss_host HOST (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // masked data compare
  task automatic chk(input logic [15:0] g, m, x);
    total_checks++;
    if ((g & m) !== (x & m)) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g & m, x & m);
    end
  endtask
  // cycle count compare against a window
  task automatic chk_t(input int g, lo, hi);
    total_checks++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("wrong value at %0t: %0d cycles, want %0d..%0d", $time, g,
               lo, hi);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for a rise, counting cycles; w picks power_ok
  task automatic wait_hi(input bit w, output int c);
    c = 0;
    while ((w ? power_ok : ramp_enable) !== 1'b1) begin
      @(posedge clk);
      #1;
      c++;
      if (c > 400) begin
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        stop_test();
      end
    end
  endtask

  // answer checker; an unexpected answer meets a note that cannot match
  always @(posedge clk) begin
    if (cmd_rvalid === 1'b1) begin
      n = (HOST.exp_q.size() > 0) ? HOST.exp_q.pop_front() : 32'hffffdead;
      chk(cmd_rdata, n[31:16], n[15:0]);
    end
  end

  initial begin
    srst = 1'b1;
    start_req = 1'b0;
    cond = '0;
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    // reset values, output off and power not good
    HOST.rd(CMD_TURN_ON_DELAY, 16'hffff, 16'h0000);
    HOST.rd(CMD_SOFT_START, 16'hffff, 16'h0001);
    HOST.rd(CMD_SUMMARY_BYTE, 16'hffff, 16'h0040);
    HOST.rd(CMD_SUMMARY_WORD, 16'hffff, 16'h0840);
    HOST.rd(CMD_VOUT_STATUS, 16'hffff, 16'h0000);
    // clamping, dropped upper bits, read-only and unmapped codes
    HOST.wr(CMD_TURN_ON_DELAY, 16'hffff);
    HOST.rd(CMD_TURN_ON_DELAY, 16'hffff, 16'h0100);
    HOST.wr(CMD_SOFT_START, 16'hfff3);
    HOST.rd(CMD_SOFT_START, 16'hffff, 16'h0ff3);
    HOST.wr(CMD_SUMMARY_BYTE, 16'h00ff);
    HOST.rd(CMD_SUMMARY_BYTE, 16'hffff, 16'h0040);
    HOST.rd(8'h50, 16'hffff, 16'h0000);
    t = $random(seed) & 16'h00ff;
    HOST.wr(CMD_TURN_ON_DELAY, t[15:0]);
    HOST.rd(CMD_TURN_ON_DELAY, 16'hffff, t[15:0]);
    // each condition but bad_switch: clear while present, then removed, then cleared
    for (int i = 0; i < 10; i++) begin
      cond[ci[i]] = 1'b1;
      HOST.wr(CMD_CLEAR_FAULTS, 16'h0000);
      repeat (6) @(posedge clk);
      HOST.rd(cc[i], 16'h1 << bi[i], 16'hffff);
      // word summaries: vout faults in bit 15, current ones in bit 14
      e = 0;
      e[15] = ci[i] inside {2, 8, 9};
      e[14] = ci[i] inside {6, 7};
      HOST.rd(CMD_SUMMARY_WORD, 16'hc000, e[15:0]);
      cond[ci[i]] = 1'b0;
      repeat (6) @(posedge clk);
      HOST.rd(cc[i], 16'h1 << bi[i], {16{lt[i]}});
      chk({15'h0, alert_out_n}, 16'h1, {15'h0, ~lt[i]});
      HOST.wr(CMD_CLEAR_FAULTS, 16'h0000);
      HOST.rd(cc[i], 16'h1 << bi[i], 16'h0000);
    end
    // power-up timing over soft-start codes 0 to 5
    HOST.wr(CMD_TURN_ON_DELAY, 16'h0002);
    for (int k = 0; k < 6; k++) begin
      HOST.wr(CMD_SOFT_START, k[15:0]);
      @(posedge clk);
      #1;
      start_req = 1'b1;
      wait_hi(1'b0, t);
      chk_t(t, 8 * MSC, 8 * MSC + 6);
      e = ((k > 3) ? 16 : (1 << k)) * MSC;
      wait_hi(1'b1, t);
      chk_t(t, e - 1, e + 2);
      HOST.rd(CMD_SUMMARY_WORD, 16'h0840, 16'h0000);
      start_req = 1'b0;
      repeat (6) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule
